// ==== include/d3cd_pkg.sv ====
// shared types and constants of the command decoder and odt transition tracker
package d3cd_pkg;
    typedef enum logic [3:0] {
        CMD_NOP  = 4'h0,
        CMD_DES  = 4'h1,
        CMD_MRS  = 4'h2,
        CMD_REF  = 4'h3,
        CMD_SRE  = 4'h4,
        CMD_SRX  = 4'h5,
        CMD_PRE  = 4'h6,
        CMD_PREA = 4'h7,
        CMD_ACT  = 4'h8,
        CMD_WR   = 4'h9,
        CMD_RD   = 4'hA,
        CMD_ZQCL = 4'hB,
        CMD_ZQCS = 4'hC,
        CMD_PDE  = 4'hD,
        CMD_PDX  = 4'hE,
        CMD_ILL  = 4'hF
    } d3cd_cmd_e;

    // gray along idle->pd->idle and idle->sr->idle
    typedef enum logic [1:0] {
        PS_IDLE = 2'h0,
        PS_PD   = 2'h1,
        PS_SR   = 2'h2
    } d3cd_pstate_e;

    typedef enum logic [1:0] {
        RSP_SYNC   = 2'h0,
        RSP_ASYNC  = 2'h1,
        RSP_EITHER = 2'h3
    } d3cd_rsp_e;

    localparam int AP_BIT = 10;
    localparam int BC_BIT = 12;
    localparam int MR0_DLL_BIT = 12;
    localparam logic [2:0] MR_SEL_MR0 = 3'h0;
    localparam logic MR0_DLL_RST = 1'h0;
    localparam logic [3:0] WL_RST = 4'h5;
    localparam int HIST_LEN = 16;
    localparam int PS_W = 20;
    localparam int WIN_W = 9;
    localparam logic [7:0] TCPDED_NCK = 8'h01;
    localparam logic [7:0] TXPDLL_NCK = 8'h0A;
    localparam logic [PS_W-1:0] TCK_LINK_PS = 20'h07D00;
    localparam logic [PS_W-1:0] TAONPD_MIN_PS = 20'h007D0;
    localparam logic [PS_W-1:0] TAONPD_MAX_PS = 20'h02134;
    localparam logic [PS_W-1:0] TAOFPD_MIN_PS = 20'h007D0;
    localparam logic [PS_W-1:0] TAOFPD_MAX_PS = 20'h02134;
    localparam logic [PS_W-1:0] TAON_MIN_PS = 20'h00000;
    localparam logic [PS_W-1:0] TAON_MAX_PS = 20'h00190;
    localparam logic [PS_W-1:0] TAOF_MIN_PS = 20'h00000;
    localparam logic [PS_W-1:0] TAOF_MAX_PS = 20'h00190;
    localparam int CMD_WORD_W = 4 + 3 + 13 + 2;
    localparam int ODT_WORD_W = 1 + 2 + 2 * PS_W;
endpackage

// ==== rtl/d3cd_xfer.sv ====
// word crossing by toggle, data held stable between loads
module d3cd_xfer #(
    parameter int W = 8
) (
    clk_src,
    clk_dst,
    rst,
    src_load,
    src_data,
    dst_valid,
    dst_data
);
    input wire logic clk_src;
    input wire logic clk_dst;
    input wire logic rst;
    input wire logic src_load;
    input wire logic [W-1:0] src_data;
    output logic dst_valid;
    output logic [W-1:0] dst_data;

    logic tog_q;
    logic [W-1:0] hold_q;
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk_src or posedge rst) begin
        if (rst) begin
            tog_q <= 1'h0;
            hold_q <= '0;
        end else if (src_load) begin
            tog_q <= ~tog_q;
            hold_q <= src_data;
        end
    end

    // needs the destination clock at least three times the source rate
    always_ff @(posedge clk_dst or posedge rst) begin
        if (rst) begin
            s1_q <= 1'h0;
            s2_q <= 1'h0;
            s3_q <= 1'h0;
        end else begin
            s1_q <= tog_q;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge clk_dst or posedge rst) begin
        if (rst) begin
            dst_valid <= 1'h0;
            dst_data <= '0;
        end else begin
            dst_valid <= s2_q ^ s3_q;
            if (s2_q ^ s3_q) begin
                dst_data <= hold_q;
            end
        end
    end

    a_xfer_single: assert property (@(posedge clk_dst) disable iff (rst)
        dst_valid |=> !dst_valid)
        else $error("crossing pulse lasted more than one cycle");
endmodule

// ==== rtl/d3cd_top.sv ====
// ddr3 command decoder with power-down exit odt transition window tracking
module d3cd_top
    import d3cd_pkg::*;
(
    clock,
    rst,
    ck_link,
    cke,
    cs_n,
    ras_n,
    cas_n,
    we_n,
    ba,
    addr,
    odt,
    wl_cfg,
    otf_en,
    cmd_valid,
    cmd_code,
    cmd_bank,
    cmd_addr,
    cmd_bc4,
    cmd_autopre,
    pd_state,
    dll_frozen,
    odt_valid,
    odt_rise,
    odt_rsp,
    rtt_min_ps,
    rtt_max_ps
);
    import d3cd_pkg::*;

    input wire logic clock;
    input wire logic rst;
    input wire logic ck_link;
    input wire logic cke;
    input wire logic cs_n;
    input wire logic ras_n;
    input wire logic cas_n;
    input wire logic we_n;
    input wire logic [2:0] ba;
    input wire logic [12:0] addr;
    input wire logic odt;
    input wire logic [3:0] wl_cfg;
    input wire logic otf_en;
    output logic cmd_valid;
    output d3cd_pkg::d3cd_cmd_e cmd_code;
    output logic [2:0] cmd_bank;
    output logic [12:0] cmd_addr;
    output logic cmd_bc4;
    output logic cmd_autopre;
    output d3cd_pkg::d3cd_pstate_e pd_state;
    output logic dll_frozen;
    output logic odt_valid;
    output logic odt_rise;
    output d3cd_pkg::d3cd_rsp_e odt_rsp;
    output logic [d3cd_pkg::PS_W-1:0] rtt_min_ps;
    output logic [d3cd_pkg::PS_W-1:0] rtt_max_ps;

    function automatic d3cd_cmd_e decode(input logic prev, input logic cur,
                                         input logic in_sr, input logic csn,
                                         input logic [2:0] rcw, input logic a10);
        decode = CMD_ILL;
        if (!prev && cur) begin
            if (csn || rcw == 3'h7) begin
                decode = in_sr ? CMD_SRX : CMD_PDX;
            end
        end else if (prev && !cur) begin
            if (!csn && rcw == 3'h1) begin
                decode = CMD_SRE;
            end else if (csn || rcw == 3'h7) begin
                decode = CMD_PDE;
            end
        end else if (!prev && !cur) begin
            decode = CMD_NOP;
        end else if (csn) begin
            decode = CMD_DES;
        end else begin
            unique case (rcw)
                3'h0: decode = CMD_MRS;
                3'h1: decode = CMD_REF;
                3'h2: decode = a10 ? CMD_PREA : CMD_PRE;
                3'h3: decode = CMD_ACT;
                3'h4: decode = CMD_WR;
                3'h5: decode = CMD_RD;
                3'h6: decode = a10 ? CMD_ZQCL : CMD_ZQCS;
                3'h7: decode = CMD_NOP;
            endcase
        end
    endfunction

    // delayed view of a history: d cycles behind the current registered value
    function automatic logic tap(input logic [HIST_LEN-1:0] h, input logic cur,
                                 input logic [3:0] d);
        tap = (d == 4'h0) ? cur : h[d - 4'h1];
    endfunction

    function automatic logic [PS_W-1:0] sync_ps(input logic [3:0] wl,
                                                input logic [PS_W-1:0] t);
        logic [3:0] odtl;
        odtl = (wl > 4'h2) ? wl - 4'h2 : 4'h0;
        sync_ps = PS_W'({16'h0, odtl} * TCK_LINK_PS) + t;
    endfunction

    function automatic logic [PS_W-1:0] pmin(input logic [PS_W-1:0] a,
                                             input logic [PS_W-1:0] b);
        pmin = (a < b) ? a : b;
    endfunction

    function automatic logic [PS_W-1:0] pmax(input logic [PS_W-1:0] a,
                                             input logic [PS_W-1:0] b);
        pmax = (a > b) ? a : b;
    endfunction

    // config comes from the clock domain and must be static while in use
    logic [3:0] wl_s1_q;
    logic [3:0] wl_q;
    logic otf_s1_q;
    logic otf_q;

    always_ff @(posedge ck_link or posedge rst) begin
        if (rst) begin
            wl_s1_q <= WL_RST;
            wl_q <= WL_RST;
            otf_s1_q <= 1'h0;
            otf_q <= 1'h0;
        end else begin
            wl_s1_q <= wl_cfg;
            wl_q <= wl_s1_q;
            otf_s1_q <= otf_en;
            otf_q <= otf_s1_q;
        end
    end

    // command pins are registered on the link clock edge
    logic cke_q;
    logic cke_prev_q;
    logic cs_n_q;
    logic [2:0] rcw_q;
    logic [2:0] ba_q;
    logic [12:0] addr_q;
    logic odt_q;

    always_ff @(posedge ck_link or posedge rst) begin
        if (rst) begin
            // idle level of cke, so release of reset is no power-down exit
            cke_q <= 1'h1;
            cke_prev_q <= 1'h1;
            cs_n_q <= 1'h1;
            rcw_q <= 3'h7;
            ba_q <= 3'h0;
            addr_q <= 13'h0;
            odt_q <= 1'h0;
        end else begin
            cke_q <= cke;
            cke_prev_q <= cke_q;
            cs_n_q <= cs_n;
            rcw_q <= {ras_n, cas_n, we_n};
            ba_q <= ba;
            addr_q <= addr;
            odt_q <= odt;
        end
    end

    d3cd_pstate_e ps_q;
    d3cd_pstate_e ps_d;
    d3cd_cmd_e cmd_d;
    logic frozen_q;
    logic mr0_a12_q;
    logic [7:0] banks_q;
    logic cmd_bc4_d;
    logic cmd_ap_d;

    assign cmd_d = decode(cke_prev_q, cke_q, ps_q == PS_SR, cs_n_q, rcw_q,
                          addr_q[AP_BIT]);
    assign cmd_bc4_d = otf_q & ~addr_q[BC_BIT];
    assign cmd_ap_d = (cmd_d == CMD_WR || cmd_d == CMD_RD) && addr_q[AP_BIT];

    always_comb begin
        ps_d = ps_q;
        unique case (ps_q)
            PS_IDLE: begin
                if (cmd_d == CMD_PDE) begin
                    ps_d = PS_PD;
                end else if (cmd_d == CMD_SRE) begin
                    ps_d = PS_SR;
                end
            end
            PS_PD: begin
                if (cmd_d == CMD_PDX) begin
                    ps_d = PS_IDLE;
                end
            end
            PS_SR: begin
                if (cmd_d == CMD_SRX) begin
                    ps_d = PS_IDLE;
                end
            end
            default: ps_d = PS_IDLE;
        endcase
    end

    always_ff @(posedge ck_link or posedge rst) begin
        if (rst) begin
            ps_q <= PS_IDLE;
        end else begin
            ps_q <= ps_d;
        end
    end

    // only precharge power-down with a12 low freezes the dll
    always_ff @(posedge ck_link or posedge rst) begin
        if (rst) begin
            frozen_q <= 1'h0;
        end else if (ps_q == PS_IDLE && cmd_d == CMD_PDE) begin
            frozen_q <= (banks_q == 8'h00) && !mr0_a12_q;
        end else if (ps_d != PS_PD) begin
            frozen_q <= 1'h0;
        end
    end

    always_ff @(posedge ck_link or posedge rst) begin
        if (rst) begin
            mr0_a12_q <= MR0_DLL_RST;
        end else if (cmd_d == CMD_MRS && ba_q == MR_SEL_MR0) begin
            mr0_a12_q <= addr_q[MR0_DLL_BIT];
        end
    end

    // auto-precharge is booked at the command, bursts are not timed here
    always_ff @(posedge ck_link or posedge rst) begin
        if (rst) begin
            banks_q <= 8'h00;
        end else begin
            unique case (cmd_d)
                CMD_ACT: banks_q[ba_q] <= 1'h1;
                CMD_PRE: banks_q[ba_q] <= 1'h0;
                CMD_PREA: banks_q <= 8'h00;
                CMD_WR, CMD_RD: begin
                    if (cmd_ap_d) begin
                        banks_q[ba_q] <= 1'h0;
                    end
                end
                default: banks_q <= banks_q;
            endcase
        end
    end

    // odt is judged wl-1 cycles late so the window can open before cke moves
    logic [3:0] lead;
    logic [HIST_LEN-1:0] odt_h_q;
    logic [HIST_LEN-1:0] frz_h_q;
    logic [WIN_W-1:0] win_q;
    logic [WIN_W-1:0] win_new;
    logic [WIN_W-1:0] win_dec;
    logic odt_old;
    logic odt_now;
    logic odt_edge;
    logic async_now;
    d3cd_rsp_e rsp_d;
    logic [PS_W-1:0] smin;
    logic [PS_W-1:0] smax;
    logic [PS_W-1:0] amin;
    logic [PS_W-1:0] amax;
    logic [PS_W-1:0] min_d;
    logic [PS_W-1:0] max_d;

    assign lead = (wl_q > 4'h1) ? wl_q - 4'h1 : 4'h0;
    assign odt_now = tap(odt_h_q, odt_q, lead);
    assign odt_old = tap(odt_h_q, odt_q, lead + 4'h1);
    assign odt_edge = odt_now ^ odt_old;
    assign async_now = tap(frz_h_q, frozen_q, lead);

    always_ff @(posedge ck_link or posedge rst) begin
        if (rst) begin
            odt_h_q <= '0;
            frz_h_q <= '0;
        end else begin
            odt_h_q <= {odt_h_q[HIST_LEN-2:0], odt_q};
            frz_h_q <= {frz_h_q[HIST_LEN-2:0], frozen_q};
        end
    end

    always_comb begin
        win_new = '0;
        if (ps_q == PS_PD && frozen_q && cmd_d == CMD_PDX) begin
            win_new = {5'h0, lead} + {1'h0, TXPDLL_NCK};
        end else if (ps_q == PS_IDLE && cmd_d == CMD_PDE && banks_q == 8'h00
                     && !mr0_a12_q) begin
            win_new = {5'h0, lead} + {1'h0, TCPDED_NCK};
        end
    end

    assign win_dec = (win_q != '0) ? win_q - 9'h001 : win_q;

    // taking the larger remainder merges overlapping windows into one span
    always_ff @(posedge ck_link or posedge rst) begin
        if (rst) begin
            win_q <= '0;
        end else begin
            win_q <= (win_new > win_dec) ? win_new : win_dec;
        end
    end

    always_comb begin
        smin = sync_ps(wl_q, odt_now ? TAON_MIN_PS : TAOF_MIN_PS);
        smax = sync_ps(wl_q, odt_now ? TAON_MAX_PS : TAOF_MAX_PS);
        amin = odt_now ? TAONPD_MIN_PS : TAOFPD_MIN_PS;
        amax = odt_now ? TAONPD_MAX_PS : TAOFPD_MAX_PS;
        if (win_q != '0) begin
            rsp_d = RSP_EITHER;
            min_d = pmin(amin, smin);
            max_d = pmax(amax, smax);
        end else if (async_now) begin
            rsp_d = RSP_ASYNC;
            min_d = amin;
            max_d = amax;
        end else begin
            rsp_d = RSP_SYNC;
            min_d = smin;
            max_d = smax;
        end
    end

    // both words move into the clock domain as plain bits, enums cast after
    logic [3:0] cmd_code_w;
    logic [1:0] odt_rsp_w;

    assign cmd_code = d3cd_cmd_e'(cmd_code_w);
    assign odt_rsp = d3cd_rsp_e'(odt_rsp_w);

    d3cd_xfer #(
        .W(CMD_WORD_W)
    ) u_cmd_xfer (
        .clk_src(ck_link),
        .clk_dst(clock),
        .rst(rst),
        .src_load(cmd_d != CMD_NOP && cmd_d != CMD_DES),
        .src_data({cmd_d, ba_q, addr_q, cmd_bc4_d, cmd_ap_d}),
        .dst_valid(cmd_valid),
        .dst_data({cmd_code_w, cmd_bank, cmd_addr, cmd_bc4, cmd_autopre})
    );

    d3cd_xfer #(
        .W(ODT_WORD_W)
    ) u_odt_xfer (
        .clk_src(ck_link),
        .clk_dst(clock),
        .rst(rst),
        .src_load(odt_edge),
        .src_data({odt_now, rsp_d, min_d, max_d}),
        .dst_valid(odt_valid),
        .dst_data({odt_rise, odt_rsp_w, rtt_min_ps, rtt_max_ps})
    );

    logic [1:0] ps_s1_q;
    logic frz_s1_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ps_s1_q <= PS_IDLE;
            pd_state <= PS_IDLE;
            frz_s1_q <= 1'h0;
            dll_frozen <= 1'h0;
        end else begin
            ps_s1_q <= ps_q;
            pd_state <= d3cd_pstate_e'(ps_s1_q);
            frz_s1_q <= frozen_q;
            dll_frozen <= frz_s1_q;
        end
    end

    a_write_decode: assert property (@(posedge ck_link) disable iff (rst)
        (cke_prev_q && cke_q && !cs_n_q && rcw_q == 3'h4) |-> cmd_d == CMD_WR)
        else $error("write pins not decoded as write");

    a_read_decode: assert property (@(posedge ck_link) disable iff (rst)
        (cke_prev_q && cke_q && !cs_n_q && rcw_q == 3'h5) |-> cmd_d == CMD_RD)
        else $error("read pins not decoded as read");

    a_otf_chop: assert property (@(posedge ck_link) disable iff (rst)
        (otf_q && (cmd_d == CMD_WR || cmd_d == CMD_RD))
        |-> cmd_bc4_d == !addr_q[BC_BIT])
        else $error("on-the-fly chop does not follow a12");

    a_autopre_close: assert property (@(posedge ck_link) disable iff (rst)
        ((cmd_d == CMD_WR || cmd_d == CMD_RD) && addr_q[AP_BIT])
        |=> !banks_q[$past(ba_q)])
        else $error("auto-precharge left bank open");

    a_mr0_capture: assert property (@(posedge ck_link) disable iff (rst)
        (cmd_d == CMD_MRS && ba_q == MR_SEL_MR0) |=> mr0_a12_q == $past(addr_q[12]))
        else $error("mr0 dll bit not captured");

    a_exit_window: assert property (@(posedge ck_link) disable iff (rst)
        (ps_q == PS_PD && frozen_q && cmd_d == CMD_PDX)
        |=> win_q >= {5'h0, $past(lead)} + {1'h0, TXPDLL_NCK})
        else $error("exit window shorter than lead plus txpdll");

    a_window_hold: assert property (@(posedge ck_link) disable iff (rst)
        (win_q > 9'h001) |=> win_q != '0)
        else $error("window closed early");

    a_sync_outside: assert property (@(posedge ck_link) disable iff (rst)
        (win_q == '0 && !async_now) |-> rsp_d == RSP_SYNC && min_d == smin)
        else $error("odt change outside window not synchronous");

    a_async_no_al: assert property (@(posedge ck_link) disable iff (rst)
        (win_q == '0 && async_now && odt_now) |-> min_d == TAONPD_MIN_PS
        && max_d == TAONPD_MAX_PS)
        else $error("async turn-on not bare pd delay");

    a_either_bounds: assert property (@(posedge ck_link) disable iff (rst)
        (win_q != '0) |-> min_d <= amin && min_d <= smin && max_d >= amax
        && max_d >= smax)
        else $error("window response bounds not min/max");

    a_pd_exit: assert property (@(posedge ck_link) disable iff (rst)
        (ps_q == PS_PD && cmd_d == CMD_PDX) |=> ps_q == PS_IDLE)
        else $error("power-down exit not taken");

    a_nop_holds: assert property (@(posedge ck_link) disable iff (rst)
        (cmd_d == CMD_NOP || cmd_d == CMD_DES) |=> $stable(banks_q))
        else $error("nop changed bank state");
endmodule

// ==== verif/d3cd_ctrl_model.sv ====
// controller model driving the command, address and odt pins on the link clock
module d3cd_ctrl_model (
    ck_link,
    cke,
    cs_n,
    ras_n,
    cas_n,
    we_n,
    ba,
    addr,
    odt
);
    timeunit 1ns;
    timeprecision 100ps;
    input wire logic ck_link;
    output logic cke;
    output logic cs_n;
    output logic ras_n;
    output logic cas_n;
    output logic we_n;
    output logic [2:0] ba;
    output logic [12:0] addr;
    output logic odt;

    // cke high from time zero so release of reset is no power-down exit
    initial begin
        cke = 1'h1;
        {cs_n, ras_n, cas_n, we_n} = 4'hF;
        ba = 3'h0;
        addr = 13'h0000;
        odt = 1'h0;
    end

    // one command, then deselect with the same cke level
    task automatic issue(input logic k, input logic [3:0] c, input logic [2:0] b,
            input logic [12:0] a);
        @(posedge ck_link);
        cke <= k;
        {cs_n, ras_n, cas_n, we_n} <= c;
        ba <= b;
        addr <= a;
        @(posedge ck_link);
        cs_n <= 1'h1;
        // deselected bus shows no stale bank or address fields
        ba <= ~b;
        addr <= ~a;
    endtask

    task automatic drive_odt(input logic v);
        @(posedge ck_link);
        odt <= v;
    endtask
endmodule

// ==== verif/d3cd_top_tb.sv ====
// self-checking bench of the command decoder and odt transition tracker
module d3cd_top_tb
    import d3cd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [23:0] DEC_TBL [12] = '{
        {4'h0, 3'h3, 13'h0123, CMD_MRS}, {4'h1, 3'h0, 13'h0000, CMD_REF},
        {4'h3, 3'h2, 13'h1ABC, CMD_ACT}, {4'h4, 3'h2, 13'h0008, CMD_WR},
        {4'h5, 3'h2, 13'h1010, CMD_RD}, {4'h5, 3'h2, 13'h0410, CMD_RD},
        {4'h3, 3'h2, 13'h0ABC, CMD_ACT}, {4'h4, 3'h2, 13'h1408, CMD_WR},
        {4'h2, 3'h5, 13'h0000, CMD_PRE}, {4'h2, 3'h0, 13'h0400, CMD_PREA},
        {4'h6, 3'h0, 13'h0400, CMD_ZQCL}, {4'h6, 3'h0, 13'h0000, CMD_ZQCS}};
    logic clock = 1'h0;
    logic ck_link = 1'h0;
    logic rst = 1'h1;
    logic [3:0] wl_cfg;
    logic otf_en;
    logic cke, cs_n, ras_n, cas_n, we_n, odt;
    logic [2:0] ba, cmd_bank;
    logic [12:0] addr, cmd_addr;
    logic cmd_valid, cmd_bc4, cmd_autopre, dll_frozen, odt_valid, odt_rise;
    d3cd_cmd_e cmd_code;
    d3cd_pstate_e pd_state;
    d3cd_rsp_e odt_rsp;
    logic [PS_W-1:0] rtt_min_ps, rtt_max_ps;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [21:0] cq[$];
    logic [42:0] oq[$];

    always #2.5 clock = ~clock;
    // link clock offset so its edges never line up with the system clock
    initial begin
        #3.7;
        forever #16 ck_link = ~ck_link;
    end

    d3cd_top u_dut (.clock, .rst, .ck_link, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba,
        .addr, .odt, .wl_cfg, .otf_en, .cmd_valid, .cmd_code, .cmd_bank, .cmd_addr,
        .cmd_bc4, .cmd_autopre, .pd_state, .dll_frozen, .odt_valid, .odt_rise, .odt_rsp,
        .rtt_min_ps, .rtt_max_ps);
    d3cd_ctrl_model u_ctrl (.ck_link, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
        .odt);

    // pulses last one clock, so collect them here rather than in the scenarios
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cmd_valid === 1'h1) begin
            cq.push_back({cmd_code, cmd_bank, cmd_addr, cmd_bc4, cmd_autopre});
        end
        if (odt_valid === 1'h1) begin
            oq.push_back({odt_rise, odt_rsp, rtt_min_ps, rtt_max_ps});
        end
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic summarize();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic exp_cmd(input d3cd_cmd_e c, input logic [2:0] b, input logic [12:0] a);
        logic [21:0] w;
        int i;
        for (i = 0; i < 60 && cq.size() == 0; i++) @(posedge clock);
        w = (cq.size() != 0) ? cq.pop_front() : 'x;
        check("cmd_code", w[21:18], c);
        if (!(c inside {CMD_PDE, CMD_PDX, CMD_SRE, CMD_SRX})) begin
            check("cmd_bank", w[17:15], b);
            check("cmd_addr", w[14:2], a);
        end
        if (c == CMD_WR || c == CMD_RD) begin
            check("cmd_bc4", w[1], otf_en & ~a[BC_BIT]);
            check("cmd_autopre", w[0], a[AP_BIT]);
        end
    endtask

    task automatic exp_odt(input logic r, input d3cd_rsp_e s);
        logic [42:0] w;
        logic [PS_W-1:0] smin, smax, pmin, pmax, emin, emax;
        int j;
        smin = TCK_LINK_PS * (wl_cfg - 4'h2) + (r ? TAON_MIN_PS : TAOF_MIN_PS);
        smax = TCK_LINK_PS * (wl_cfg - 4'h2) + (r ? TAON_MAX_PS : TAOF_MAX_PS);
        pmin = r ? TAONPD_MIN_PS : TAOFPD_MIN_PS;
        pmax = r ? TAONPD_MAX_PS : TAOFPD_MAX_PS;
        emin = (s == RSP_SYNC) ? smin : (s == RSP_ASYNC) ? pmin : (smin < pmin ? smin : pmin);
        emax = (s == RSP_SYNC) ? smax : (s == RSP_ASYNC) ? pmax : (smax > pmax ? smax : pmax);
        for (j = 0; j < 120 && oq.size() == 0; j++) @(posedge clock);
        w = (oq.size() != 0) ? oq.pop_front() : 'x;
        check("odt_rise", w[42], r);
        check("odt_rsp", w[41:40], s);
        check("rtt_min_ps", w[39:20], emin);
        check("rtt_max_ps", w[19:0], emax);
    endtask

    task automatic t_decode(input logic otf);
        int i;
        @(posedge clock);
        otf_en <= otf;
        repeat (20) @(posedge clock);
        for (i = 0; i < 12; i++) begin
            u_ctrl.issue(1'h1, DEC_TBL[i][23:20], DEC_TBL[i][19:17], DEC_TBL[i][16:4]);
            exp_cmd(d3cd_cmd_e'(DEC_TBL[i][3:0]), DEC_TBL[i][19:17], DEC_TBL[i][16:4]);
        end
    endtask

    // nop and deselect must not be reported ahead of the refresh
    task automatic t_idle();
        u_ctrl.issue(1'h1, 4'h7, 3'h1, 13'h0011);
        u_ctrl.issue(1'h1, 4'h8, 3'h1, 13'h0011);
        u_ctrl.issue(1'h1, 4'h1, 3'h4, 13'h0022);
        exp_cmd(CMD_REF, 3'h4, 13'h0022);
    endtask

    task automatic t_selfref();
        u_ctrl.issue(1'h0, 4'h1, 3'h0, 13'h0000);
        exp_cmd(CMD_SRE, 3'h0, 13'h0000);
        repeat (10) @(posedge clock);
        check("pd_state", pd_state, PS_SR);
        u_ctrl.issue(1'h1, 4'h7, 3'h0, 13'h0000);
        exp_cmd(CMD_SRX, 3'h0, 13'h0000);
        repeat (10) @(posedge clock);
        check("pd_state", pd_state, PS_IDLE);
    endtask

    // dll kept running through power-down: odt answers stay synchronous
    task automatic t_dll_on();
        u_ctrl.issue(1'h1, 4'h0, 3'h0, 13'h1000);
        exp_cmd(CMD_MRS, 3'h0, 13'h1000);
        u_ctrl.issue(1'h0, 4'h7, 3'h0, 13'h0000);
        exp_cmd(CMD_PDE, 3'h0, 13'h0000);
        repeat (20) @(posedge ck_link);
        check("dll_frozen", dll_frozen, 1'h0);
        u_ctrl.drive_odt(1'h1);
        exp_odt(1'h1, RSP_SYNC);
        u_ctrl.issue(1'h1, 4'h7, 3'h0, 13'h0000);
        exp_cmd(CMD_PDX, 3'h0, 13'h0000);
        u_ctrl.drive_odt(1'h0);
        exp_odt(1'h0, RSP_SYNC);
        u_ctrl.issue(1'h1, 4'h0, 3'h0, 13'h0000);
        exp_cmd(CMD_MRS, 3'h0, 13'h0000);
    endtask

    task automatic t_pd();
        u_ctrl.issue(1'h0, 4'h7, 3'h0, 13'h0000);
        exp_cmd(CMD_PDE, 3'h0, 13'h0000);
        repeat (20) @(posedge ck_link);
        check("pd_state", pd_state, PS_PD);
        check("dll_frozen", dll_frozen, 1'h1);
        u_ctrl.drive_odt(1'h1);
        exp_odt(1'h1, RSP_ASYNC);
        repeat (10) @(posedge ck_link);
        u_ctrl.issue(1'h1, 4'h7, 3'h0, 13'h0000);
        u_ctrl.drive_odt(1'h0);
        u_ctrl.drive_odt(1'h1);
        exp_cmd(CMD_PDX, 3'h0, 13'h0000);
        exp_odt(1'h0, RSP_EITHER);
        exp_odt(1'h1, RSP_EITHER);
        repeat (30) @(posedge ck_link);
        u_ctrl.drive_odt(1'h0);
        exp_odt(1'h0, RSP_SYNC);
    endtask

    // changes just before exit and between short idle spans stay uncertain
    task automatic t_short_pd();
        u_ctrl.issue(1'h0, 4'h7, 3'h0, 13'h0000);
        u_ctrl.drive_odt(1'h1);
        u_ctrl.issue(1'h1, 4'h7, 3'h0, 13'h0000);
        u_ctrl.issue(1'h0, 4'h7, 3'h0, 13'h0000);
        u_ctrl.drive_odt(1'h0);
        u_ctrl.issue(1'h1, 4'h7, 3'h0, 13'h0000);
        exp_cmd(CMD_PDE, 3'h0, 13'h0000);
        exp_cmd(CMD_PDX, 3'h0, 13'h0000);
        exp_cmd(CMD_PDE, 3'h0, 13'h0000);
        exp_cmd(CMD_PDX, 3'h0, 13'h0000);
        exp_odt(1'h1, RSP_EITHER);
        exp_odt(1'h0, RSP_EITHER);
    endtask

    // reset also spans two link edges so the pin registers clear
    initial begin
        wl_cfg <= 4'h5;
        otf_en <= 1'h0;
        repeat (10) @(posedge clock);
        repeat (2) @(posedge ck_link);
        @(posedge clock);
        rst <= 1'h0;
        repeat (4) @(posedge ck_link);
        t_decode(1'h0);
        t_decode(1'h1);
        t_idle();
        t_selfref();
        t_dll_on();
        t_pd();
        t_short_pd();
        // odt history must be flat before the lead moves, or a false edge shows
        repeat (100) @(posedge clock);
        wl_cfg <= 4'h7;
        repeat (40) @(posedge clock);
        t_pd();
        summarize();
    end
endmodule
